/* File: core/cmlf_pkg.sv */
// How it works
// [RULE_01] One 16-byte fill buffer holds last line
// [RULE_02] Enabled cacheable miss outside SRAM starts external fetch
// [RULE_03] Data misses always fetch a full line
// [RULE_04] Select 00: longword only at offset 11
// [RULE_05] Select 01: longword at offsets 10, 11
// [RULE_06] Select 1X: instruction misses fetch full line
// [RULE_07] Line fetch starts at critical longword
// [RULE_08] Remaining longwords follow, wrapping modulo 16
// [RULE_09] Buffer load sets most-recently-used flag
// [RULE_10] Access to matching array index clears flag
// [RULE_11] Next miss writes full, newer buffer back
// [RULE_12] Odd word branch gives word-sized fetch
// [RULE_13] Burst bit: noncacheable fills buffer, never array (code: instruction fetches only)
// [RULE_14] Cache off: word or longword fetches only
// [RULE_15] Burst bit clear: noncacheable bypasses buffer
// [RULE_16] SRAM hits override cache, never cached
// [RULE_17] Software may prefer select 00 or 01
// [RULE_18] Reset clears control, disables cache
// [RULE_19] Fill buffer tracks valid per longword
package cmlf_pkg;

  localparam int unsigned ADDR_W      = 32;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned LW_PER_LINE = 4;
  localparam int unsigned REG_ADDR_W  = 4;

  // Register offsets
  localparam logic [REG_ADDR_W-1:0] OFS_CTRL   = 4'h0;
  localparam logic [REG_ADDR_W-1:0] OFS_STATUS = 4'h4;

  // Control register fields
  localparam int unsigned CTRL_ON_BIT    = 31;
  localparam int unsigned CTRL_BURST_BIT = 10;
  localparam int unsigned CTRL_FILL_LO   = 0;
  localparam int unsigned CTRL_SPLIT_BIT = 4;
  localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] CTRL_MASK  = 32'h8000_0413;

  // Status register fields
  localparam int unsigned STAT_MRU_BIT  = 0;
  localparam int unsigned STAT_VLD_LO   = 4;
  localparam int unsigned STAT_BUSY_BIT = 8;
  localparam int unsigned STAT_NC_BIT   = 9;

  typedef enum logic [1:0] {
    CMLF_SZ_WORD,
    CMLF_SZ_LONG,
    CMLF_SZ_LINE
  } cmlf_size_e;

  typedef struct packed {
    logic                 valid;
    logic [ADDR_W-1:0]    addr;
    logic                 instr;
    logic                 cacheable;
    logic                 word;
  } cmlf_req_s;

  typedef struct packed {
    logic                 valid;
    logic [ADDR_W-1:0]    addr;
    cmlf_size_e           size;
  } cmlf_ext_s;

  typedef struct packed {
    logic                 valid;
    logic [6:0]           index;
    logic [ADDR_W-1:5]    tag_hi;
    logic [ADDR_W-1:0]    line_addr;
    logic [4*DATA_W-1:0]  line;
  } cmlf_wb_s;

endpackage : cmlf_pkg

/* File: core/cmlf_fill_buf.sv */
`timescale 1ns/1ns
`default_nettype none
module cmlf_fill_buf
  import cmlf_pkg::*;
(
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      rst_b,
  // Control
  input  wire logic                      clear,
  input  wire logic                      load,
  input  wire logic [cmlf_pkg::ADDR_W-1:0] load_addr,
  input  wire logic [1:0]                word_sel,
  input  wire logic [cmlf_pkg::DATA_W-1:0] word_data,
  // Lookup
  input  wire logic [cmlf_pkg::ADDR_W-1:0] look_addr,
  output logic                           look_hit,
  output logic [cmlf_pkg::DATA_W-1:0]    look_data,
  // Contents
  output logic [cmlf_pkg::ADDR_W-1:0]    line_addr,
  output logic [cmlf_pkg::LW_PER_LINE-1:0] word_valid,
  output logic [4*cmlf_pkg::DATA_W-1:0]  line_data
);
  import cmlf_pkg::*;

  logic [DATA_W-1:0] mem [LW_PER_LINE];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      line_addr <= '0;
    end else if (clear) begin
      line_addr <= {load_addr[ADDR_W-1:4], 4'h0};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      word_valid <= '0;
    end else if (clear) begin
      word_valid <= '0;
    end else if (load) begin
      word_valid[word_sel] <= 1'b1; // see [RULE_19]
    end
  end

  always_ff @(posedge sys_clk) begin
    if (load) begin
      mem[word_sel] <= word_data; // see [RULE_01]
    end
  end

  always_comb begin
    look_hit  = (look_addr[ADDR_W-1:4] == line_addr[ADDR_W-1:4]) && word_valid[look_addr[3:2]];
    look_data = mem[look_addr[3:2]];
    line_data = {mem[3], mem[2], mem[1], mem[0]};
  end

endmodule : cmlf_fill_buf
`default_nettype wire

/* File: core/cmlf_miss_fill.sv */
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module cmlf_miss_fill
  import cmlf_pkg::*;
(
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Register port
  input  wire logic [cmlf_pkg::REG_ADDR_W-1:0] reg_addr,
  input  wire logic [cmlf_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic [cmlf_pkg::DATA_W-1:0]      reg_rdata,
  // Core request
  input  wire cmlf_pkg::cmlf_req_s         req,
  input  wire logic                        tag_hit,
  input  wire logic [cmlf_pkg::DATA_W-1:0] array_data,
  input  wire logic                        sram_hit,
  input  wire logic [cmlf_pkg::DATA_W-1:0] sram_data,
  output logic                             req_ready,
  output logic                             rsp_valid,
  output logic [cmlf_pkg::DATA_W-1:0]      rsp_data,
  // External fetch
  output cmlf_pkg::cmlf_ext_s              ext_req,
  input  wire logic                        ext_ack,
  input  wire logic                        ext_dvalid,
  input  wire logic [cmlf_pkg::DATA_W-1:0] ext_data,
  // Array write
  output cmlf_pkg::cmlf_wb_s               array_wr
);
  import cmlf_pkg::*;

  typedef enum logic [1:0] {
    CMLF_IDLE,
    CMLF_ISSUE,
    CMLF_FILL
  } cmlf_state_e;

  //////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic cmlf_size_e fill_size(input logic instr, input logic [1:0] sel,
                                           input logic [1:0] ofs);
    cmlf_size_e s;
    s = CMLF_SZ_LINE;
    if (instr) begin
      if (sel == 2'b00 && ofs == 2'b11) begin
        s = CMLF_SZ_LONG; // see [RULE_04]
      end else if (sel == 2'b01 && ofs[1]) begin
        s = CMLF_SZ_LONG; // see [RULE_05]
      end
      // Upper select bit always keeps a line, see [RULE_06]
    end
    return s; // see [RULE_03]
  endfunction : fill_size

  function automatic logic [6:0] line_index(input logic [ADDR_W-1:0] a, input logic split);
    return split ? {1'b0, a[9:4]} : a[10:4];
  endfunction : line_index

  //////////////////////////////////////////////////////////////////////////////
  // Control register

  logic [DATA_W-1:0] cache_control_reg;
  logic              cache_on_bit;
  logic              noncache_instr_burst_bit;
  logic [1:0]        fill_size_select;
  logic              split_cfg;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cache_control_reg <= CTRL_RESET; // see [RULE_18]
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      cache_control_reg <= reg_wdata & CTRL_MASK;
    end
  end

  always_comb begin
    cache_on_bit             = cache_control_reg[CTRL_ON_BIT];
    noncache_instr_burst_bit = cache_control_reg[CTRL_BURST_BIT];
    fill_size_select         = cache_control_reg[CTRL_FILL_LO +: 2];
    split_cfg                = cache_control_reg[CTRL_SPLIT_BIT];
  end

  //////////////////////////////////////////////////////////////////////////////
  // Fill buffer

  cmlf_state_e        state;
  logic [1:0]         beat;
  logic [1:0]         start_ofs;
  logic [2:0]         beats_left;
  logic               mru;
  logic               buf_nc;
  logic               buf_clear;
  logic               buf_load;
  logic [ADDR_W-1:0]  miss_addr;
  logic               buf_hit;
  logic [DATA_W-1:0]  buf_data;
  logic [ADDR_W-1:0]  buf_addr;
  logic [LW_PER_LINE-1:0] buf_valid;
  logic [4*DATA_W-1:0] buf_line;

  cmlf_fill_buf u_buf (
    .sys_clk    (sys_clk),
    .rst_b      (rst_b),
    .clear      (buf_clear),
    .load       (buf_load),
    .load_addr  (miss_addr),
    .word_sel   (beat),
    .word_data  (ext_data),
    .look_addr  (req.addr),
    .look_hit   (buf_hit),
    .look_data  (buf_data),
    .line_addr  (buf_addr),
    .word_valid (buf_valid),
    .line_data  (buf_line)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Request classification

  logic take;
  logic use_cache;
  logic use_buf;
  logic hit_now;
  logic miss;
  logic single;
  logic next_nc;
  cmlf_size_e next_size;

  always_comb begin
    take      = req.valid && state == CMLF_IDLE;
    // Cache path for cacheable, or for burst noncacheable instructions
    use_cache = cache_on_bit && !sram_hit &&
                (req.cacheable || (req.instr && noncache_instr_burst_bit)); // see [RULE_13]
    use_buf   = use_cache;
    hit_now   = use_buf && (buf_hit || (req.cacheable && tag_hit));
    miss      = take && use_cache && !hit_now; // see [RULE_02]
    single    = take && !sram_hit && !use_cache; // see [RULE_14] [RULE_15]
    next_nc   = !req.cacheable;
    next_size = fill_size(req.instr, fill_size_select, req.addr[3:2]);
    req_ready = state == CMLF_IDLE;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Miss state machine

  logic bypass;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state      <= CMLF_IDLE;
      miss_addr  <= '0;
      start_ofs  <= '0;
      beats_left <= '0;
      bypass     <= 1'b0;
      buf_nc     <= 1'b0;
      ext_req    <= '0;
    end else begin
      unique case (state)
        CMLF_IDLE: begin
          if (miss || single) begin
            state         <= CMLF_ISSUE;
            miss_addr     <= req.addr;
            start_ofs     <= req.addr[3:2]; // see [RULE_07]
            bypass        <= single;
            ext_req.valid <= 1'b1;
            if (single) begin
              beats_left   <= 3'd1;
              // Odd word branch fetches one word, see [RULE_12]
              ext_req.size <= req.word ? CMLF_SZ_WORD : CMLF_SZ_LONG;
              ext_req.addr <= req.addr;
            end else begin
              buf_nc       <= next_nc;
              ext_req.size <= next_size;
              beats_left   <= (next_size == CMLF_SZ_LINE) ? 3'd4 : 3'd1;
              ext_req.addr <= {req.addr[ADDR_W-1:2], 2'b00};
            end
          end
        end
        CMLF_ISSUE: begin
          if (ext_ack) begin
            ext_req.valid <= 1'b0;
            state         <= CMLF_FILL;
          end
        end
        CMLF_FILL: begin
          if (ext_dvalid) begin
            beats_left <= beats_left - 3'd1;
            if (beats_left == 3'd1) begin
              state <= CMLF_IDLE;
            end
          end
        end
        default: state <= CMLF_IDLE;
      endcase
    end
  end

  // Beat order wraps modulo 16 from the critical longword
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      beat <= '0;
    end else if (state == CMLF_IDLE) begin
      beat <= req.addr[3:2];
    end else if (state == CMLF_FILL && ext_dvalid) begin
      beat <= beat + 2'd1; // see [RULE_08]
    end
  end

  always_comb begin
    // The old line leaves on the miss edge, so the buffer is cleared one cycle later
    buf_clear = state == CMLF_ISSUE && !bypass; // see [RULE_15]
    buf_load  = state == CMLF_FILL && ext_dvalid && !bypass; // see [RULE_01]
  end

  //////////////////////////////////////////////////////////////////////////////
  // Most-recently-used tracking

  logic idx_touch;

  always_comb begin
    idx_touch = take && use_cache && req.cacheable && tag_hit && !buf_hit &&
                line_index(req.addr, split_cfg) == line_index(buf_addr, split_cfg);
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      mru <= 1'b0;
    end else if (miss) begin
      mru <= 1'b1; // see [RULE_09]
    end else if (idx_touch) begin
      mru <= 1'b0; // see [RULE_10]
    end
  end

  // Write back of the previous line on the next miss
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      array_wr <= '0;
    end else begin
      array_wr.valid <= miss && mru && (&buf_valid) && !buf_nc; // see [RULE_11] [RULE_13]
      array_wr.index     <= line_index(buf_addr, split_cfg);
      array_wr.tag_hi    <= buf_addr[ADDR_W-1:5];
      array_wr.line_addr <= buf_addr;
      array_wr.line      <= buf_line;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Response

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rsp_valid <= 1'b0;
      rsp_data  <= '0;
    end else if (take && sram_hit) begin
      rsp_valid <= 1'b1;
      rsp_data  <= sram_data; // see [RULE_16]
    end else if (take && hit_now) begin
      rsp_valid <= 1'b1;
      rsp_data  <= buf_hit ? buf_data : array_data;
    end else if (state == CMLF_FILL && ext_dvalid &&
                 (bypass || beat == start_ofs)) begin
      rsp_valid <= 1'b1;
      rsp_data  <= ext_data;
    end else begin
      rsp_valid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Register read

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      unique case (reg_addr)
        OFS_CTRL:   reg_rdata <= cache_control_reg;
        OFS_STATUS: begin
          reg_rdata                             <= '0;
          reg_rdata[STAT_MRU_BIT]               <= mru;
          reg_rdata[STAT_VLD_LO +: LW_PER_LINE] <= buf_valid;
          reg_rdata[STAT_BUSY_BIT]              <= state != CMLF_IDLE;
          reg_rdata[STAT_NC_BIT]                <= buf_nc;
        end
        default:    reg_rdata <= '0;
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

endmodule : cmlf_miss_fill
`default_nettype wire

/* File: test/cmlf_miss_fill_checker.sv */
`timescale 1ns/1ns
`default_nettype none
module cmlf_miss_fill_checker
  import cmlf_pkg::*;
(
  // Clock, reset and registers
  input wire logic                              sys_clk,
  input wire logic                              rst_b,
  input wire logic [cmlf_pkg::REG_ADDR_W-1:0]   reg_addr,
  input wire logic [cmlf_pkg::DATA_W-1:0]       reg_wdata,
  input wire logic                              reg_wr,
  input wire logic                              reg_rd,
  input wire logic [cmlf_pkg::DATA_W-1:0]       reg_rdata,
  // Core side
  input wire cmlf_pkg::cmlf_req_s               req,
  input wire logic                              tag_hit,
  input wire logic                              sram_hit,
  input wire logic [cmlf_pkg::DATA_W-1:0]       sram_data,
  input wire logic                              req_ready,
  input wire logic                              rsp_valid,
  input wire logic [cmlf_pkg::DATA_W-1:0]       rsp_data,
  // Fetch and write-back
  input wire cmlf_pkg::cmlf_ext_s               ext_req,
  input wire logic                              ext_ack,
  input wire cmlf_pkg::cmlf_wb_s                array_wr
);
  import cmlf_pkg::*;

  logic [DATA_W-1:0] ctrl;
  logic [1:0]        crit;
  logic              line_q;
  wire logic         acc  = req.valid && req_ready;
  wire logic         miss = acc && !(tag_hit && req.cacheable) && !sram_hit;
  wire logic         on   = ctrl[CTRL_ON_BIT];

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RESET;
    end else if (reg_wr && reg_addr == OFS_CTRL) begin
      ctrl <= reg_wdata & CTRL_MASK;
    end
  end

  // Fill size expected from the select field and the miss offset
  always_ff @(posedge sys_clk) begin
    crit <= req.addr[3:2];
    line_q <= ctrl[CTRL_FILL_LO+1] | (ctrl[CTRL_FILL_LO] ? !req.addr[3] : req.addr[3:2] != 2'b11);
  end

  ////////////////////////////////////////
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  property p_fetch; miss && on && req.cacheable |=> ext_req.valid || rsp_valid; endproperty
  a_fetch: assert property (p_fetch)
    else $error("cacheable miss gave no fetch");
  property p_data; miss && on && req.cacheable && !req.instr |=> !ext_req.valid
    || ext_req.size == CMLF_SZ_LINE; endproperty
  a_data: assert property (p_data)
    else $error("data miss not a line");
  property p_instr; miss && on && req.cacheable && req.instr |=> !ext_req.valid
    || (ext_req.size == CMLF_SZ_LINE) == line_q; endproperty
  a_instr: assert property (p_instr)
    else $error("instruction fill size wrong");
  property p_crit; miss |=> !ext_req.valid || ext_req.addr[3:2] == crit; endproperty
  a_crit: assert property (p_crit)
    else $error("critical longword not first");
  property p_off; acc && !sram_hit && !on && req.instr |=> ext_req.size != CMLF_SZ_LINE;
  endproperty
  a_off: assert property (p_off)
    else $error("line fetch with cache off");
  property p_nc; acc && !sram_hit && on && !req.cacheable && !ctrl[CTRL_BURST_BIT]
    |=> ext_req.size != CMLF_SZ_LINE; endproperty
  a_nc: assert property (p_nc)
    else $error("noncacheable line without burst bit");
  property p_sram; acc && sram_hit |=> rsp_valid && !ext_req.valid
    && rsp_data == $past(sram_data); endproperty
  a_sram: assert property (p_sram)
    else $error("memory region data not returned");
  property p_hold; ext_req.valid && !ext_ack |=> ext_req.valid && $stable(ext_req.addr)
    && !req_ready; endproperty
  a_hold: assert property (p_hold)
    else $error("fetch request dropped early");
  property p_wb; array_wr.valid |-> $past(miss) && !$past(array_wr.valid); endproperty
  a_wb: assert property (p_wb)
    else $error("write-back outside a miss");
  property p_ctrl; reg_rd && reg_addr == OFS_CTRL |=> reg_rdata == ctrl; endproperty
  a_ctrl: assert property (p_ctrl)
    else $error("control readback wrong");
endmodule : cmlf_miss_fill_checker
`default_nettype wire

/* File: test/cmlf_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cmlf_bus_model
  import cmlf_pkg::*;
(
  // Clock and reset
  input  wire logic                        sys_clk,
  input  wire logic                        rst_b,
  // Stall every other cycle
  input  wire logic                        slow,
  // Fetch channel
  input  wire cmlf_pkg::cmlf_ext_s         ext_req,
  output logic                             ext_ack,
  output logic                             ext_dvalid,
  output logic [cmlf_pkg::DATA_W-1:0]      ext_data
);
  import cmlf_pkg::*;

  logic [2:0]        left;
  logic [ADDR_W-1:0] base;
  logic              go;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ext_ack <= 1'b0;
      ext_dvalid <= 1'b0;
      ext_data <= '0;
      left <= '0;
      base <= '0;
      go <= 1'b0;
    end else begin
      go <= slow ? !go : 1'b1;
      ext_ack <= 1'b0;
      ext_dvalid <= 1'b0;
      // Idle data line inverts each cycle, so the next cycle never repeats the last beat
      ext_data <= ~ext_data;
      if (ext_req.valid && !ext_ack && left == 3'd0 && go) begin
        ext_ack <= 1'b1;
        base <= ext_req.addr;
        left <= (ext_req.size == CMLF_SZ_LINE) ? 3'd4 : 3'd1;
      end else if (left != 3'd0 && go) begin
        ext_dvalid <= 1'b1;
        ext_data <= {~base[15:0], base[15:0]};
        base[3:2] <= base[3:2] + 2'd1;
        left <= left - 3'd1;
      end
    end
  end
endmodule : cmlf_bus_model
`default_nettype wire

/* File: test/cmlf_miss_fill_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module cmlf_miss_fill_bench;
  import cmlf_pkg::*;
  typedef struct packed {
    logic [DATA_W-1:0] ctrl;
    logic              ins;
    logic              cach;
    logic              word;
    logic [3:0]        lines;
  } cmlf_row_s;
  logic                  sys_clk = 1'b0;
  logic                  rst_b = 1'b0;
  logic                  slow = 1'b0;
  logic [REG_ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0]     reg_wdata = '0;
  logic                  reg_wr = 1'b0;
  logic                  reg_rd = 1'b0;
  cmlf_req_s             req = '0;
  logic                  tag_hit = 1'b0;
  logic                  sram_hit = 1'b0;
  logic [DATA_W-1:0]     array_data = 32'h1234_5678;
  logic [DATA_W-1:0]     sram_data = 32'hCAFE_0001;
  logic [DATA_W-1:0]     reg_rdata, rsp_data, ext_data, rd_v;
  logic                  req_ready, rsp_valid, ext_ack, ext_dvalid;
  cmlf_ext_s             ext_req;
  cmlf_wb_s              array_wr, wb;
  cmlf_size_e            ext_sz;
  logic [ADDR_W-1:0]     ext_a, a, la, lb, lc, ld;
  logic [4*DATA_W-1:0]   ln;
  int                    n_errors = 0, tests_run = 0, n_ext = 0, n_wb = 0, w0;
  cmlf_row_s             rows [9] = '{
    '{32'h8000_0000, 1'b1, 1'b1, 1'b0, 4'h7},
    '{32'h8000_0001, 1'b1, 1'b1, 1'b0, 4'h3},
    '{32'h8000_0002, 1'b1, 1'b1, 1'b0, 4'hF},
    '{32'h8000_0003, 1'b1, 1'b1, 1'b0, 4'hF},
    '{32'h8000_0000, 1'b0, 1'b1, 1'b0, 4'hF},
    '{32'h0000_0402, 1'b1, 1'b1, 1'b0, 4'h0},
    '{32'h8000_0002, 1'b1, 1'b0, 1'b0, 4'h0},
    '{32'h8000_0401, 1'b1, 1'b0, 1'b0, 4'h3},
    '{32'h0000_0000, 1'b1, 1'b1, 1'b1, 4'h0}
  };

  cmlf_miss_fill i_cmlf_miss_fill (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .req, .tag_hit, .array_data, .sram_hit, .sram_data, .req_ready, .rsp_valid,
    .rsp_data, .ext_req, .ext_ack, .ext_dvalid, .ext_data, .array_wr);
  cmlf_bus_model i_cmlf_bus_model (.sys_clk, .rst_b, .slow, .ext_req, .ext_ack, .ext_dvalid,
    .ext_data);

  always #5 sys_clk = ~sys_clk;

  always @(posedge sys_clk) begin
    if (ext_req.valid && ext_ack) begin
      n_ext++;
      ext_sz = ext_req.size;
      ext_a = ext_req.addr;
    end
    if (array_wr.valid) begin
      n_wb++;
      wb = array_wr;
    end
  end

  ////////////////////////////////////////
  function automatic logic [DATA_W-1:0] dat(input logic [ADDR_W-1:0] x);
    return {~x[15:0], x[15:0]};
  endfunction : dat
  task automatic chk(input logic ok, input string m);
    tests_run++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [REG_ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [REG_ADDR_W-1:0] ad);
    @(posedge sys_clk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(negedge sys_clk);
    rd_v = reg_rdata;
  endtask : rd
  task automatic fetch(input logic [ADDR_W-1:0] ad, input logic i, c, w,
                       input cmlf_size_e sz, input int x, input logic [DATA_W-1:0] d);
    int n0;
    int k;
    n0 = n_ext;
    k = 0;
    @(posedge sys_clk);
    req <= '{1'b1, ad, i, c, w};
    @(posedge sys_clk);
    req.valid <= 1'b0;
    do begin @(negedge sys_clk); k++; end while (rsp_valid !== 1'b1 && k < 40);
    chk(rsp_valid === 1'b1 && rsp_data === d, "response data");
    do begin @(negedge sys_clk); k++; end while (req_ready !== 1'b1 && k < 80);
    chk(n_ext - n0 == x, "fetch count");
    if (x == 1) chk(ext_sz === sz && ext_a === (w ? {ad[31:1], 1'b0} : {ad[31:2], 2'b00}),
                    "fetch size or address");
  endtask : fetch
  task automatic end_sim();
    $display("Checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    end_sim();
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (rows[r]) begin
      wr(OFS_CTRL, rows[r].ctrl);
      for (int o = 0; o < 4; o++) begin
        a = 32'h0001_0000 + (r * 4 + o) * 16 + o * 4 + (rows[r].word ? 2 : 0);
        fetch(a, rows[r].ins, rows[r].cach, rows[r].word, rows[r].lines[o] ? CMLF_SZ_LINE
              : (rows[r].word ? CMLF_SZ_WORD : CMLF_SZ_LONG), 1, dat(a));
      end
    end
    @(posedge sys_clk) slow <= 1'b1;
    wr(OFS_CTRL, 32'h8000_0002);
    la = 32'h0002_0048;
    fetch(la, 1, 1, 0, CMLF_SZ_LINE, 1, dat(la));
    rd(OFS_STATUS);
    chk(rd_v[9:0] === 10'h0F1, "status after fill");
    fetch(la + 4, 1, 1, 0, CMLF_SZ_LINE, 0, dat(la + 4));
    w0 = n_wb;
    lb = 32'h0002_0550;
    fetch(lb, 0, 1, 0, CMLF_SZ_LINE, 1, dat(lb));
    for (int i = 0; i < 4; i++) ln[32*i+:32] = dat({la[31:4], 2'(i), 2'b00});
    chk(n_wb == w0 + 1 && wb.index === la[10:4] && wb.line === ln, "line write");
    chk(wb.tag_hi === la[31:5] && wb.line_addr === {la[31:4], 4'h0}, "line address");
    @(posedge sys_clk) tag_hit <= 1'b1;
    fetch(lb ^ 32'h800, 1, 1, 0, CMLF_SZ_LINE, 0, array_data);
    @(posedge sys_clk) tag_hit <= 1'b0;
    rd(OFS_STATUS);
    chk(rd_v[STAT_MRU_BIT] === 1'b0, "indicator not cleared");
    lc = 32'h0002_0660;
    fetch(lc, 1, 1, 0, CMLF_SZ_LINE, 1, dat(lc));
    chk(n_wb == w0 + 1, "older buffer written");
    wr(OFS_CTRL, 32'h8000_0402);
    ld = 32'h0003_0020;
    fetch(ld, 1, 0, 0, CMLF_SZ_LINE, 1, dat(ld));
    chk(n_wb == w0 + 2 && wb.index === lc[10:4], "newer buffer kept");
    rd(OFS_STATUS);
    chk(rd_v[STAT_NC_BIT] === 1'b1, "noncacheable mark");
    fetch(ld + 12, 1, 0, 0, CMLF_SZ_LINE, 0, dat(ld + 12));
    la = lc + 32;
    fetch(la, 1, 1, 0, CMLF_SZ_LINE, 1, dat(la));
    chk(n_wb == w0 + 2, "noncacheable line written");
    wr(OFS_CTRL, 32'h8000_0012);
    fetch(lb + 32, 0, 1, 0, CMLF_SZ_LINE, 1, dat(lb + 32));
    chk(n_wb == w0 + 3 && wb.index === {1'b0, la[9:4]}, "split index");
    @(posedge sys_clk) sram_hit <= 1'b1;
    fetch(32'h0004_0000, 1, 1, 0, CMLF_SZ_LINE, 0, sram_data);
    @(posedge sys_clk) sram_hit <= 1'b0;
    @(posedge sys_clk) rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(OFS_CTRL);
    chk(rd_v === CTRL_RESET, "control after reset");
    rd(4'h8);
    chk(rd_v === 32'h0000_0000, "unmapped read");
    wr(OFS_CTRL, 32'hFFFF_FFFF);
    rd(OFS_CTRL);
    chk(rd_v === CTRL_MASK, "reserved bits kept");
    end_sim();
  end
endmodule : cmlf_miss_fill_bench

bind cmlf_miss_fill cmlf_miss_fill_checker i_cmlf_miss_fill_checker (.sys_clk, .rst_b,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .req, .tag_hit, .sram_hit, .sram_data,
  .req_ready, .rsp_valid, .rsp_data, .ext_req, .ext_ack, .array_wr);
`default_nettype wire
